// ===== rtl/evm_vector_map.sv
// Purpose: map exceptions, traps and interrupt requests to vector number, level, address
// Assumes: requests are levels held until the core acknowledges the vector
// Notes: lowest vector number wins; the core fetches reset then mode vector after reset
//
// Contract
// - reset uses vector 0, offset 3fc, default fetch 000ffffc
// - mode vector is vector 1, offset 3f8, fetched in reset sequence
// - coprocessor absent traps via 7, coprocessor error via 8
// - debug trap instruction uses vector 9, instruction breakpoint uses 10
// - operand breakpoint uses vector 11, step trace uses 12
// - debug tool non-maskable request uses vector 13
// - undefined instruction uses vector 14, offset 3c4
// - ordinary non-maskable request uses vector 15, level fixed at 15
// - external inputs 0-7 map to vectors 16-23, level entries 0-7
// - reload timers 0-2 use vectors 24-26, level entries 8-10
// - serial receive 0-2 use vectors 27-29, level entries 11-13
// - serial transmit 0-2 use vectors 30-32, level entries 14-16
// - fetch address is table base plus 3fc minus four times vector
// - table spans 1 Kbyte from base, four bytes per entry
// - each peripheral request has its own level register
`timescale 1ns/1ps
module evm_vector_map
    import evm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [31:0] vector_table_base_in,
    input wire logic [FIXED_NUM-1:0] fixed_req_in,
    input wire logic [PERIPH_NUM-1:0] periph_req_in,
    input wire logic vec_ack_in,
    input wire logic level_wr_in,
    input wire logic [4:0] level_idx_in,
    input wire logic [LEVEL_W-1:0] level_data_in,
    output logic vec_valid_out,
    output logic [7:0] vec_num_out,
    output logic [LEVEL_W-1:0] vec_level_out,
    output logic [31:0] vec_addr_out
);
    evm_state_type state_reg, state_next;
    logic valid_reg, valid_next;
    logic [7:0] num_reg, num_next;
    logic [LEVEL_W-1:0] level_reg, level_next;
    logic [31:0] addr_reg, addr_next;
    logic [4:0] pidx_reg, pidx_next;
    logic [31:0] base_reg, base_next;
    logic [LEVEL_W-1:0] mem_level;
    logic [4:0] pfind;
    logic [7:0] ffind;
    logic fany;
    logic pany;

    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] v);
        return base + {22'h0, VEC_OFS_TOP - {v, 2'b00}};
    endfunction

    // lowest vector first; bit i of the fixed group is vector 7+i
    always_comb begin
        fany = 1'b0;
        ffind = VEC_NMI;
        for (int i = FIXED_NUM - 1; i >= 0; i--) begin
            if (fixed_req_in[i]) begin
                fany = 1'b1;
                ffind = VEC_FIXED_BASE + 8'(i);
            end
        end
        pany = 1'b0;
        pfind = 5'h0;
        for (int j = PERIPH_NUM - 1; j >= 0; j--) begin
            if (periph_req_in[j]) begin
                pany = 1'b1;
                pfind = 5'(j);
            end
        end
    end

    evm_level_mem u_level (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .wr_en_in(level_wr_in),
        .wr_idx_in(level_idx_in),
        .wr_data_in(level_data_in),
        .rd_idx_in(pfind),
        .rd_data_out(mem_level)
    );

    always_comb begin
        state_next = state_reg;
        valid_next = valid_reg;
        num_next = num_reg;
        level_next = level_reg;
        addr_next = addr_reg;
        pidx_next = pidx_reg;
        // base kept as loaded, so a table move mid-vector cannot upset the offset checks
        base_next = base_reg;
        case (state_reg)
            ST_RST: begin
                valid_next = 1'b1;
                base_next = vector_table_base_in;
                num_next = VEC_RESET;
                level_next = NMI_LEVEL;
                addr_next = vec_addr(vector_table_base_in, VEC_RESET);
                if (valid_reg && vec_ack_in) begin
                    state_next = ST_MODE;
                    num_next = VEC_MODE;
                    addr_next = vec_addr(vector_table_base_in, VEC_MODE);
                end
            end
            ST_MODE: begin
                if (vec_ack_in) begin
                    valid_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // only mapped sources reach here, reserved numbers cannot appear
                if (fany) begin
                    valid_next = 1'b1;
                    num_next = ffind;
                    level_next = (ffind == VEC_NMI) ? NMI_LEVEL : '0;
                    addr_next = vec_addr(vector_table_base_in, ffind);
                    base_next = vector_table_base_in;
                    state_next = ST_PRES;
                end else if (pany) begin
                    pidx_next = pfind;
                    state_next = ST_LOOK;
                end
            end
            ST_LOOK: begin
                // level read one cycle late: the store keeps its read port registered
                valid_next = 1'b1;
                num_next = VEC_PERIPH_BASE + {3'h0, pidx_reg};
                level_next = mem_level;
                addr_next = vec_addr(vector_table_base_in, VEC_PERIPH_BASE + {3'h0, pidx_reg});
                base_next = vector_table_base_in;
                state_next = ST_PRES;
            end
            ST_PRES: begin
                if (vec_ack_in) begin
                    valid_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                valid_next = 1'b0;
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= ST_RST;
            valid_reg <= 1'b0;
            num_reg <= VEC_RESET;
            level_reg <= NMI_LEVEL;
            addr_reg <= TBR_DEFAULT;
            pidx_reg <= 5'h0;
            base_reg <= TBR_DEFAULT;
        end else begin
            state_reg <= state_next;
            valid_reg <= valid_next;
            num_reg <= num_next;
            level_reg <= level_next;
            addr_reg <= addr_next;
            pidx_reg <= pidx_next;
            base_reg <= base_next;
        end
    end

    assign vec_valid_out = valid_reg;
    assign vec_num_out = num_reg;
    assign vec_level_out = level_reg;
    assign vec_addr_out = addr_reg;

    property p_reset_vec;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (state_reg == ST_RST && valid_reg) |-> (num_reg == 8'h00 && addr_reg - base_reg == 32'h3fc);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

    property p_mode_follows;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (state_reg == ST_RST && valid_reg && vec_ack_in) |=> (valid_reg && num_reg == 8'h01);
    endproperty
    a_mode_follows: assert property (p_mode_follows) else $error("mode vector missing");

    property p_cop_absent;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (state_reg == ST_IDLE && fixed_req_in[0]) |=> (valid_reg && num_reg == 8'h07);
    endproperty
    a_cop_absent: assert property (p_cop_absent) else $error("coprocessor trap vector wrong");

    property p_debug_trap;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (state_reg == ST_IDLE && fixed_req_in[2:0] == 3'h4) |=> (num_reg == 8'h09);
    endproperty
    a_debug_trap: assert property (p_debug_trap) else $error("debug trap vector wrong");

    property p_step;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (state_reg == ST_IDLE && fixed_req_in[5:0] == 6'h20) |=> (num_reg == 8'h0c);
    endproperty
    a_step: assert property (p_step) else $error("step trace vector wrong");

    property p_nmi_level;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (valid_reg && num_reg == 8'h0f) |-> (level_reg == 4'hf);
    endproperty
    a_nmi_level: assert property (p_nmi_level) else $error("nmi level not 15");

    property p_ext0;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (state_reg == ST_IDLE && fixed_req_in == '0 && periph_req_in[0])
            |-> ##2 (valid_reg && num_reg == 8'h10);
    endproperty
    a_ext0: assert property (p_ext0) else $error("external 0 vector wrong");

    property p_offset;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (valid_reg && $stable(base_reg)) |-> (addr_reg - base_reg == 32'h3fc - {22'h0, num_reg, 2'b00});
    endproperty
    a_offset: assert property (p_offset) else $error("fetch offset wrong");

    property p_span;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (valid_reg && $stable(base_reg)) |-> (addr_reg - base_reg < 32'h400 && addr_reg[1:0] == base_reg[1:0]);
    endproperty
    a_span: assert property (p_span) else $error("fetch outside table");

    property p_no_reserved;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        valid_reg |-> !(num_reg >= 8'h02 && num_reg <= 8'h06);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved vector produced");
endmodule

// ===== inc/evm_pkg.sv
// Purpose: constants for the exception vector map
// Assumes: one 50 MHz core clock, vectors 0 to 32 only
// Notes: levels are four bits wide, 15 being the fixed non-maskable level
package evm_pkg;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_MODE = 8'h01;
    localparam logic [7:0] VEC_RSV_LO = 8'h02;
    localparam logic [7:0] VEC_RSV_HI = 8'h06;
    localparam logic [7:0] VEC_FIXED_BASE = 8'h07;
    localparam logic [7:0] VEC_NMI = 8'h0f;
    localparam logic [7:0] VEC_PERIPH_BASE = 8'h10;
    localparam logic [7:0] VEC_TIMER0 = 8'h18;
    localparam logic [7:0] VEC_RX0 = 8'h1b;
    localparam logic [7:0] VEC_TX0 = 8'h1e;
    localparam logic [9:0] VEC_OFS_TOP = 10'h3fc;
    localparam logic [31:0] TABLE_BYTES = 32'h0000_0400;
    localparam logic [31:0] TBR_DEFAULT = 32'h000f_fc00;
    localparam logic [3:0] NMI_LEVEL = 4'hf;
    localparam logic [3:0] LEVEL_RST = 4'hf;
    localparam int FIXED_NUM = 9;
    localparam int PERIPH_NUM = 17;
    localparam int LEVEL_W = 4;
    // gray codes along reset -> mode -> idle -> lookup -> present
    typedef enum logic [2:0] {
        ST_RST = 3'h0,
        ST_MODE = 3'h1,
        ST_IDLE = 3'h3,
        ST_LOOK = 3'h2,
        ST_PRES = 3'h6
    } evm_state_type;
endpackage

// ===== rtl/evm_level_mem.sv
// Purpose: per-source level storage with registered read data
// Assumes: one write and one read per cycle
// Notes: a read in the cycle of a write to the same entry returns the old level
`timescale 1ns/1ps
module evm_level_mem
    import evm_pkg::*;
#(
    parameter int DEPTH = PERIPH_NUM,
    parameter int WIDTH = LEVEL_W,
    parameter int AW = 5
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_idx_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_idx_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] rd_reg;
    logic [WIDTH-1:0] rd_next;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    mem_reg[g] <= LEVEL_RST;
                end else if (wr_en_in && wr_idx_in == AW'(g)) begin
                    mem_reg[g] <= wr_data_in;
                end
            end
        end
    endgenerate

    always_comb begin
        rd_next = (rd_idx_in < AW'(DEPTH)) ? mem_reg[rd_idx_in] : LEVEL_RST;
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_reg <= LEVEL_RST;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign rd_data_out = rd_reg;
endmodule

// ===== sim/evm_core_model.sv
// Purpose: core side that takes each presented vector with a one-cycle ack
// Assumes: ack changes on the falling edge, delay_in sets how slow the core is
// Notes: re-arms only when valid drops or the number changes, so no vector is taken twice
`timescale 1ns/1ps
module evm_core_model (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic vec_valid_in,
    input wire logic [7:0] vec_num_in,
    input wire logic [3:0] delay_in,
    output logic vec_ack_out
);
    logic [3:0] wait_reg;
    logic armed_reg;
    logic [7:0] taken_reg;
    always @(negedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vec_ack_out <= 1'b0;
            wait_reg <= 4'h0;
            armed_reg <= 1'b1;
            taken_reg <= 8'hff;
        end else if (vec_ack_out) begin
            vec_ack_out <= 1'b0;
            armed_reg <= 1'b0;
            wait_reg <= 4'h0;
        end else if (!armed_reg) begin
            armed_reg <= !vec_valid_in || vec_num_in != taken_reg;
        end else if (vec_valid_in) begin
            if (wait_reg >= delay_in) begin
                vec_ack_out <= 1'b1;
                taken_reg <= vec_num_in;
            end else begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule

// ===== sim/testbench.sv
// Purpose: self-checking bench for the exception vector map
// Assumes: inputs change on the falling edge, requests drop after their ack
// Notes: expected vectors come from a priority walk over the bench's own request copy
`timescale 1ns/1ps
module testbench;
    import evm_pkg::*;
    logic clk_sys_in, arst_n_in, vec_ack_in, level_wr_in;
    logic [31:0] base;
    logic [FIXED_NUM-1:0] fixed_req;
    logic [PERIPH_NUM-1:0] periph_req;
    logic [4:0] level_idx;
    logic [3:0] level_data, delay;
    logic vec_valid_out;
    logic [7:0] vec_num_out;
    logic [3:0] vec_level_out;
    logic [31:0] vec_addr_out;
    int err_count = 0, checked = 0, seed = 23, cycles = 0;
    int lvl[PERIPH_NUM];
    int expq[$];
    evm_vector_map dut_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .vector_table_base_in(base), .fixed_req_in(fixed_req), .periph_req_in(periph_req),
        .vec_ack_in(vec_ack_in), .level_wr_in(level_wr_in), .level_idx_in(level_idx),
        .level_data_in(level_data), .vec_valid_out(vec_valid_out), .vec_num_out(vec_num_out),
        .vec_level_out(vec_level_out), .vec_addr_out(vec_addr_out));
    evm_core_model core_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .vec_valid_in(vec_valid_out), .vec_num_in(vec_num_out), .delay_in(delay),
        .vec_ack_out(vec_ack_in));
    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic serve(input int num);
        int lv, t;
        lv = (num == 15 || num < 2) ? 15 : (num >= 16 ? lvl[num-16] : 0);
        t = 0;
        while (vec_valid_out !== 1'b1 && t < 20) begin
            @(negedge clk_sys_in);
            t++;
        end
        checked++;
        if (vec_valid_out !== 1'b1 || vec_num_out !== 8'(num) || vec_level_out !== 4'(lv)
            || vec_addr_out !== base + 32'h3fc - 32'(4 * num)) begin
            err_count++;
            $display("CHECK FAILED %0t vector %0d got %0d", $time, num, vec_num_out);
        end
        t = 0;
        @(posedge clk_sys_in);
        while (vec_ack_in !== 1'b1 && t < 20) begin
            @(posedge clk_sys_in);
            t++;
        end
        if (vec_ack_in !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED %0t vector %0d never acknowledged", $time, num);
        end
        @(negedge clk_sys_in);
        if (num >= 16) periph_req[num-16] = 1'b0;
        else if (num >= 7) fixed_req[num-7] = 1'b0;
        t = 0;
        while (vec_valid_out === 1'b1 && vec_num_out === 8'(num) && t < 4) begin
            @(negedge clk_sys_in);
            t++;
        end
        if (vec_valid_out === 1'b1 && vec_num_out === 8'(num)) begin
            err_count++;
            $display("CHECK FAILED %0t vector %0d still presented after ack", $time, num);
        end
    endtask
    task automatic do_reset();
        arst_n_in = 1'b0;
        base = TBR_DEFAULT;
        foreach (lvl[i]) lvl[i] = 15;
        repeat (6) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        serve(0);
        serve(1);
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // a hang costs a mismatch and still reaches the verdict
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("CHECK FAILED %0t timeout", $time);
            end_of_test();
        end
    end
    initial begin
        {fixed_req, periph_req, level_wr_in, level_idx, level_data, delay} = '0;
        do_reset();
        for (int i = 0; i < FIXED_NUM; i++) begin
            base = {$random(seed)} & 32'hffff_fc00;
            delay = 4'({$random(seed)} % 4);
            fixed_req[i] = 1'b1;
            serve(7 + i);
        end
        level_wr_in = 1'b1;
        for (int p = 0; p < 18; p++) begin
            level_idx = (p == 17) ? 5'h1f : 5'(p);
            level_data = 4'($random(seed));
            if (p < 17) lvl[p] = int'(level_data);
            @(negedge clk_sys_in);
        end
        level_wr_in = 1'b0;
        for (int p = 0; p < PERIPH_NUM; p++) begin
            periph_req[p] = 1'b1;
            serve(16 + p);
        end
        repeat (20) begin
            fixed_req = FIXED_NUM'($random(seed) & $random(seed));
            periph_req = PERIPH_NUM'($random(seed));
            delay = 4'({$random(seed)} % 6);
            // fixed sources win over peripherals, lower number first
            expq = {};
            for (int i = 0; i < FIXED_NUM; i++) if (fixed_req[i]) expq.push_back(7 + i);
            for (int p = 0; p < PERIPH_NUM; p++) if (periph_req[p]) expq.push_back(16 + p);
            while (expq.size() > 0) serve(expq.pop_front());
        end
        @(negedge clk_sys_in);
        do_reset();
        periph_req[5] = 1'b1;
        serve(21);
        end_of_test();
    end
endmodule
